// File: hw/lcr_dom_if.sv
// Request and answer of one reset domain
interface lcr_dom_if;
   logic req;
   logic held;
   logic done;
   modport ctrl (output req, input held, input done);
   modport dom  (input req, output held, output done);
endinterface

// File: hw/lcr_domain.sv
// One clock domain: sync release, hold, status
module lcr_domain
(
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   lcr_dom_if.dom    port_if
);
   logic                          sync_rst_n;
   logic [lcr_pkg::HOLD_WIDTH-1:0] hold_cnt;
   lcr_pkg::lcr_state_t           state;

   // Release aligned to this clock
   lcr_rst_sync u_sync
   (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i & ~port_if.req),
      .rst_n_o  (sync_rst_n)
   );

   // Hold a few cycles, then run
   always_ff @(posedge clk_i or negedge sync_rst_n)
   begin
      if (!sync_rst_n)
      begin
         state    <= lcr_pkg::LCR_ST_HELD;
         hold_cnt <= '0;
      end
      else
      begin
         case (state)
            lcr_pkg::LCR_ST_HELD:
               state <= lcr_pkg::LCR_ST_RELEASING;
            lcr_pkg::LCR_ST_RELEASING:
            begin
               hold_cnt <= hold_cnt + 1'b1;
               if (hold_cnt == lcr_pkg::HOLD_CYCLES)
                  state <= lcr_pkg::LCR_ST_RUN;
            end
            lcr_pkg::LCR_ST_RUN:
               state <= lcr_pkg::LCR_ST_RUN;
            default:
               state <= lcr_pkg::LCR_ST_HELD;
         endcase
      end
   end

   assign port_if.held = (state != lcr_pkg::LCR_ST_RUN);
   assign port_if.done = (state == lcr_pkg::LCR_ST_RUN);
endmodule // lcr_domain

// File: hw/lcr_pkg.sv
package lcr_pkg;
   // Domain indices of the reset distribution
   localparam int DOM_RX    = 0;
   localparam int DOM_EXT   = 1;
   localparam int DOM_LAT   = 2;
   localparam int DOM_RCFG  = 3;
   localparam int DOM_CPU   = 4;
   localparam int DOM_MTX   = 5;
   localparam int DOM_MRX   = 6;
   localparam int DOM_GTX   = 7;
   localparam int DOM_GRX   = 8;
   localparam int DOM_COUNT = 9;

   // Synchroniser depth and release hold
   localparam int SYNC_STAGES  = 2;
   localparam int HOLD_WIDTH   = 4;
   localparam logic [HOLD_WIDTH-1:0] HOLD_CYCLES = 4'h3;

   // Reset-domain state
   typedef enum logic [1:0] {
      LCR_ST_HELD,
      LCR_ST_RELEASING,
      LCR_ST_RUN
   } lcr_state_t;
endpackage

// File: hw/lcr_rst_sync.sv
// Asserts async, releases on clock after two stages
module lcr_rst_sync
#(
   parameter int STAGES = lcr_pkg::SYNC_STAGES
)
(
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   output      logic rst_n_o
);
   logic [STAGES-1:0] chain;

   // Shift a one in after release
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         chain <= '0;
      else
         chain <= {chain[STAGES-2:0], 1'b1};
   end

   assign rst_n_o = chain[STAGES-1];
endmodule // lcr_rst_sync

// File: hw/lcr_top.sv
// Function
// - Receive reset clears receive datapath logic
// - Extended-delay reset restarts delay measurement
// - Latency reset clears FIFO delay measurement
// - Reconfig reset clears reconfig interface, registers
// - Reconfig reset joins rate switching on 28-nm
// - Reconfig reset absent when options all off
// - Processor reset clears register interface
// - MII transmit reset clears write side
// - MII receive reset clears read side
// - GMII transmit reset clears write side
// - GMII receive reset clears read side
// - Global reset spares registers, delay, transceiver
module lcr_top
#(
   parameter bit HAS_RCFG_RESET = 1'b1,
   parameter bit LEGACY_28NM    = 1'b0
)
(
   input  wire logic clk_sys_i,
   input  wire logic nrst_i,
   input  wire logic reset_n_i,
   input  wire logic rx_rst_l_i,
   input  wire logic ext_dly_meas_rst_l_i,
   input  wire logic ext_dly_meas_clock_i,
   input  wire logic lat_rst_l_i,
   input  wire logic lat_clk_i,
   input  wire logic reconfig_clk_i,
   input  wire logic reconfig_rst_i,
   input  wire logic rate_switch_req_i,
   input  wire logic cpu_rst_l_i,
   input  wire logic cpu_clk_i,
   input  wire logic mii_tx_rst_l_i,
   input  wire logic mii_tx_clk_i,
   input  wire logic mii_rx_rst_l_i,
   input  wire logic mii_rx_clk_i,
   input  wire logic gmii_tx_rst_l_i,
   input  wire logic gmii_tx_clk_i,
   input  wire logic gmii_rx_rst_l_i,
   input  wire logic gmii_rx_clk_i,
   output      logic [lcr_pkg::DOM_COUNT-1:0] dom_rst_l_o,
   output      logic [lcr_pkg::DOM_COUNT-1:0] dom_ready_o
);
   logic                          sys_rst_n;
   logic [lcr_pkg::DOM_COUNT-1:0] dom_clk;
   logic [lcr_pkg::DOM_COUNT-1:0] dom_arst_n;
   logic [lcr_pkg::DOM_COUNT-1:0] dom_held;
   logic [lcr_pkg::DOM_COUNT-1:0] dom_done;
   logic [lcr_pkg::DOM_COUNT-1:0] held_m;
   logic [lcr_pkg::DOM_COUNT-1:0] held_s;
   logic [lcr_pkg::DOM_COUNT-1:0] done_m;
   logic [lcr_pkg::DOM_COUNT-1:0] done_s;
   logic                          rcfg_rst_n;

   // System reset released through two flops
   lcr_rst_sync u_sys_sync
   (
      .clk_i    (clk_sys_i),
      .arst_n_i (nrst_i),
      .rst_n_o  (sys_rst_n)
   );

   // Reconfig reset is active high; absent when options off
   assign rcfg_rst_n = HAS_RCFG_RESET ? ~reconfig_rst_i : 1'b1;

   // Clock of each domain
   always_comb
   begin
      dom_clk                    = '0;
      dom_clk[lcr_pkg::DOM_RX]   = reconfig_clk_i;
      dom_clk[lcr_pkg::DOM_EXT]  = ext_dly_meas_clock_i;
      dom_clk[lcr_pkg::DOM_LAT]  = lat_clk_i;
      dom_clk[lcr_pkg::DOM_RCFG] = reconfig_clk_i;
      dom_clk[lcr_pkg::DOM_CPU]  = cpu_clk_i;
      dom_clk[lcr_pkg::DOM_MTX]  = mii_tx_clk_i;
      dom_clk[lcr_pkg::DOM_MRX]  = mii_rx_clk_i;
      dom_clk[lcr_pkg::DOM_GTX]  = gmii_tx_clk_i;
      dom_clk[lcr_pkg::DOM_GRX]  = gmii_rx_clk_i;
   end

   // Asynchronous reset of each domain; global only on receive path
   always_comb
   begin
      dom_arst_n = '1;
      dom_arst_n[lcr_pkg::DOM_RX]   = rx_rst_l_i & reset_n_i;
      dom_arst_n[lcr_pkg::DOM_EXT]  = ext_dly_meas_rst_l_i;
      dom_arst_n[lcr_pkg::DOM_LAT]  = lat_rst_l_i;
      dom_arst_n[lcr_pkg::DOM_RCFG] = rcfg_rst_n;
      dom_arst_n[lcr_pkg::DOM_CPU]  = cpu_rst_l_i;
      dom_arst_n[lcr_pkg::DOM_MTX]  = mii_tx_rst_l_i;
      dom_arst_n[lcr_pkg::DOM_MRX]  = mii_rx_rst_l_i;
      dom_arst_n[lcr_pkg::DOM_GTX]  = gmii_tx_rst_l_i;
      dom_arst_n[lcr_pkg::DOM_GRX]  = gmii_rx_rst_l_i;
   end

   // One synchronised domain per reset
   for (genvar d = 0; d < lcr_pkg::DOM_COUNT; d++)
   begin : g_dom
      lcr_dom_if dif ();
      if (d == lcr_pkg::DOM_RCFG)
      begin : g_rs
         // Rate switch also resets reconfig on 28-nm parts
         assign dif.req = LEGACY_28NM & HAS_RCFG_RESET
                          & rate_switch_req_i;
      end
      else
      begin : g_nrs
         assign dif.req = 1'b0;
      end
      // Released on its own clock; input held a clock
      lcr_domain u_dom
      (
         .clk_i    (dom_clk[d]),
         .arst_n_i (dom_arst_n[d]),
         .port_if  (dif)
      );
      assign dom_held[d] = dif.held;
      assign dom_done[d] = dif.done;
   end

   // Bring domain status into the system clock
   always_ff @(posedge clk_sys_i or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         held_m <= '1;
         held_s <= '1;
         done_m <= '0;
         done_s <= '0;
      end
      else
      begin
         held_m <= dom_held;
         held_s <= held_m;
         done_m <= dom_done;
         done_s <= done_m;
      end
   end

   // Registered outputs
   always_ff @(posedge clk_sys_i or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         dom_rst_l_o <= '0;
         dom_ready_o <= '0;
      end
      else
      begin
         dom_rst_l_o <= ~held_s;
         dom_ready_o <= done_s;
      end
   end
endmodule // lcr_top

// File: verification/lcr_rst_src.sv
// Outside reset source with free-running domain clocks
module lcr_rst_src
(
   input  wire logic [8:0] want_l_i,
   output      logic [8:0] clk_o,
   output      logic [8:0] rst_l_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // One clock and one reset line per domain
   for (genvar i = 0; i < 9; i++)
   begin : g_dom
      initial
      begin
         clk_o[i] = 1'b0;
         forever #(9 + i) clk_o[i] = ~clk_o[i];
      end
      // Assert at once, release on own edge
      always @(posedge clk_o[i] or negedge want_l_i[i])
         rst_l_o[i] <= want_l_i[i];
   end
   // Global reset is driven apart from these lines
endmodule // lcr_rst_src

// File: verification/lcr_top_asserts.sv
// Watches the top ports for per-domain reset behaviour
module lcr_top_asserts
(
   input wire logic clk_sys_i, nrst_i, reset_n_i, rx_rst_l_i,
   input wire logic ext_dly_meas_rst_l_i, ext_dly_meas_clock_i,
   input wire logic lat_rst_l_i, lat_clk_i, reconfig_clk_i,
   input wire logic reconfig_rst_i, rate_switch_req_i, cpu_rst_l_i,
   input wire logic cpu_clk_i, mii_tx_rst_l_i, mii_tx_clk_i,
   input wire logic mii_rx_rst_l_i, mii_rx_clk_i, gmii_tx_rst_l_i,
   input wire logic gmii_tx_clk_i, gmii_rx_rst_l_i, gmii_rx_clk_i,
   input wire logic [lcr_pkg::DOM_COUNT-1:0] dom_rst_l_o,
   input wire logic [lcr_pkg::DOM_COUNT-1:0] dom_ready_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   rx_held_a: assert property (!rx_rst_l_i[*3] |-> ##[0:5]
      !dom_rst_l_o[0]) else $error("rx domain not held");
   ext_held_a: assert property (!ext_dly_meas_rst_l_i[*3] |-> ##[0:5]
      !dom_rst_l_o[1]) else $error("ext domain not held");
   lat_held_a: assert property (!lat_rst_l_i[*3] |-> ##[0:5]
      !dom_rst_l_o[2]) else $error("lat domain not held");
   rcfg_held_a: assert property (reconfig_rst_i[*3] |-> ##[0:5]
      !dom_rst_l_o[3]) else $error("reconfig domain not held");
   cpu_held_a: assert property (!cpu_rst_l_i[*3] |-> ##[0:5]
      !dom_rst_l_o[4]) else $error("cpu domain not held");
   mtx_held_a: assert property (!mii_tx_rst_l_i[*3] |-> ##[0:5]
      !dom_rst_l_o[5]) else $error("mii tx domain not held");
   mrx_held_a: assert property (!mii_rx_rst_l_i[*3] |-> ##[0:5]
      !dom_rst_l_o[6]) else $error("mii rx domain not held");
   gtx_held_a: assert property (!gmii_tx_rst_l_i[*3] |-> ##[0:5]
      !dom_rst_l_o[7]) else $error("gmii tx domain not held");
   grx_held_a: assert property (!gmii_rx_rst_l_i[*3] |-> ##[0:5]
      !dom_rst_l_o[8]) else $error("gmii rx domain not held");
   rx_release_a: assert property ($rose(dom_ready_o[0]) |->
      $past(rx_rst_l_i, 3) && rx_rst_l_i) else $error("rx early run");
endmodule // lcr_top_asserts
bind lcr_top lcr_top_asserts lcr_top_asserts_inst (.*);

// File: verification/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys_i, nrst_i, reset_n_i, rs;
   logic [8:0] w, ck, r, dom_rst_l_o, dom_ready_o;
   int         fails, n_checks;
   lcr_rst_src lcr_rst_src_inst (.want_l_i(w), .clk_o(ck), .rst_l_o(r));
   lcr_top #(.HAS_RCFG_RESET(1'b1), .LEGACY_28NM(1'b1))
   lcr_top_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .reset_n_i(reset_n_i), .rx_rst_l_i(r[0]),
      .ext_dly_meas_rst_l_i(r[1]), .ext_dly_meas_clock_i(ck[1]),
      .lat_rst_l_i(r[2]), .lat_clk_i(ck[2]), .reconfig_clk_i(ck[3]),
      .reconfig_rst_i(!r[3]), .rate_switch_req_i(rs),
      .cpu_rst_l_i(r[4]), .cpu_clk_i(ck[4]), .mii_tx_rst_l_i(r[5]),
      .mii_tx_clk_i(ck[5]), .mii_rx_rst_l_i(r[6]), .mii_rx_clk_i(ck[6]),
      .gmii_tx_rst_l_i(r[7]), .gmii_tx_clk_i(ck[7]),
      .gmii_rx_rst_l_i(r[8]), .gmii_rx_clk_i(ck[8]),
      .dom_rst_l_o(dom_rst_l_o), .dom_ready_o(dom_ready_o));
   // System clock, 40 ns
   initial
   begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   task check(input string nm, input logic [8:0] e, input logic [8:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   // Bounded wait until every domain runs
   task wait_run();
      for (int i = 0; i < 60 && dom_ready_o !== 9'h1ff; i++)
         @(negedge clk_sys_i);
      check("ready", 9'h1ff, dom_ready_o);
      check("rst_l", 9'h1ff, dom_rst_l_o);
   endtask
   // Each domain reset alone clears only its own domain
   task t_each();
      for (int k = 0; k < 9; k++)
      begin
         w[k] = 1'b0;
         repeat (6) @(negedge clk_sys_i);
         check("held", ~(9'h1 << k), dom_rst_l_o);
         check("idle", ~(9'h1 << k), dom_ready_o);
         w[k] = 1'b1;
         wait_run();
      end
      $display("t_each done");
   endtask
   // Global reset spares cpu, delay and other domains
   task t_global();
      reset_n_i = 1'b0;
      repeat (6) @(negedge clk_sys_i);
      check("global", 9'h1fe, dom_rst_l_o);
      check("global_rdy", 9'h1fe, dom_ready_o);
      reset_n_i = 1'b1;
      wait_run();
      $display("t_global done");
   endtask
   // Rate switch request resets only the reconfig domain
   task t_rate();
      rs = 1'b1;
      repeat (6) @(negedge clk_sys_i);
      check("rate_held", 9'h1f7, dom_rst_l_o);
      check("rate_idle", 9'h1f7, dom_ready_o);
      rs = 1'b0;
      wait_run();
      $display("t_rate done");
   endtask
   task close_out();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #100us;
      fails++;
      close_out();
   end
   initial
   begin
      nrst_i = 1'b0;
      reset_n_i = 1'b1;
      rs = 1'b0;
      w = 9'h0;
      fails = 0;
      n_checks = 0;
      repeat (3) @(negedge clk_sys_i);
      check("in_reset", 9'h0, dom_rst_l_o);
      nrst_i = 1'b1;
      w = 9'h1ff;
      wait_run();
      t_each();
      t_global();
      t_rate();
      close_out();
   end
endmodule // testbench
